// File: mbx_avalon_front.sv
`timescale 1ns/1ps
module mbx_avalon_front
	import mbx_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] readWord,
	output logic avs_waitrequest,
	output logic [31:0] avs_readdata,
	output logic commitWrite,
	output logic [5:0] commitAddr,
	output logic [31:0] commitData
);
	// ----------------------------------------
	// Two-cycle answer: sample, then release waitrequest
	// ----------------------------------------
	mbx_bus_e busState;

	always_ff @(posedge clk) begin
		if (rst) begin
			busState <= MBX_BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			case (busState)
				MBX_BUS_IDLE: begin
					if (avs_read || avs_write) begin
						busState <= MBX_BUS_ANSWER;
						avs_waitrequest <= 1'b0;
					end
				end
				MBX_BUS_ANSWER: begin
					busState <= MBX_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					busState <= MBX_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Read data captured while waitrequest is still high
	always_ff @(posedge clk) begin
		if (rst) begin
			avs_readdata <= MBX_ZERO_WORD;
		end else if (ce) begin
			if (busState == MBX_BUS_IDLE && avs_read) begin
				avs_readdata <= readWord;
			end
		end
	end

	// Writes land on the edge the master sees waitrequest low
	assign commitWrite = ce && busState == MBX_BUS_ANSWER && avs_write;
	assign commitAddr = avs_address;
	assign commitData = avs_writedata & mbx_be_mask(avs_byteenable);
endmodule

// File: mbx_core_model.sv
`timescale 1ns/1ps
module mbx_core_model
	import mbx_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic goRead,
	input wire logic [5:0] goAddr,
	input wire logic [31:0] goData,
	output logic done,
	output logic [31:0] rdata,
	output logic [5:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata
);
	// ----------------------------------------
	// One core issuing single word transfers
	// ----------------------------------------
	logic busy;
	assign avs_byteenable = 4'hF;
	initial begin
		busy = 1'b0;
		done = 1'b0;
		rdata = 32'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h0;
		avs_writedata = 32'h0;
	end
	always @(posedge clk) begin
		done <= !rst && busy && avs_waitrequest === 1'b0;
		if (rst) begin
			busy <= 1'b0;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end else if (!busy && go) begin
			busy <= 1'b1;
			avs_read <= goRead;
			avs_write <= !goRead;
			avs_address <= goAddr;
			avs_writedata <= goData;
		end else if (busy && avs_waitrequest === 1'b0) begin
			busy <= 1'b0;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			// Released lines must not keep looking valid
			avs_address <= ~avs_address;
			avs_writedata <= ~avs_writedata;
			rdata <= avs_readdata;
		end
	end
endmodule

// File: mbx_mailbox_regs.sv
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module mbx_mailbox_regs
	import mbx_pkg::*;
#(
	parameter int MAILBOX_INDEX = 0
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic avs_waitrequest,
	output logic [31:0] avs_readdata,
	input wire logic linkPrevSend,
	output logic linkNextSend,
	output logic ownerClearPulse,
	output logic [31:0] channel_irq_out
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic commitWrite;
	logic [5:0] commitAddr;
	logic [31:0] commitData;
	logic [31:0] readWord;
	logic [31:0] mailbox_owner_reg;
	logic [1:0] mailbox_mode_reg;
	logic [1:0] send_control_reg;
	logic [1:0] send_control_next;
	logic [31:0] destVec;
	logic [31:0] maskVec;
	logic destWasSet_reg;
	logic claimed;
	logic wrOwner;
	logic wrMode;
	logic wrSend;
	logic ownerClear;
	logic ownerLoad;
	logic autoAckFire;
	logic linkFire;
	logic [31:0] rawIrq;

	// ----------------------------------------
	// Bus front and vectors
	// ----------------------------------------
	mbx_avalon_front uFront (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.readWord(readWord),
		.avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata),
		.commitWrite(commitWrite),
		.commitAddr(commitAddr),
		.commitData(commitData)
	);

	assign claimed = |mailbox_owner_reg;
	assign wrOwner = commitWrite && commitAddr == MBX_OFS_OWNER;
	assign wrMode = commitWrite && commitAddr == MBX_OFS_MODE && claimed;
	assign wrSend = commitWrite && commitAddr == MBX_OFS_SEND && claimed;
	assign ownerClear = wrOwner && commitData == MBX_ZERO_WORD;
	// Nonzero over nonzero is dropped; software must clear first
	assign ownerLoad = wrOwner && !claimed && commitData != MBX_ZERO_WORD;

	// Destination vector; cleared with the owner in any mode
	mbx_setclr_vec uDest (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.clearAll(ownerClear),
		.setEn(commitWrite && commitAddr == MBX_OFS_DSET && claimed),
		.clrEn(commitWrite && commitAddr == MBX_OFS_DCLR && claimed),
		.bits(commitData),
		.value(destVec)
	);

	// Mask vector; resets to zero so channels start in polling
	mbx_setclr_vec uMask (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.clearAll(ownerClear),
		.setEn(commitWrite && commitAddr == MBX_OFS_MSET && claimed),
		.clrEn(commitWrite && commitAddr == MBX_OFS_MCLR && claimed),
		.bits(commitData),
		.value(maskVec)
	);

	// ----------------------------------------
	// Owner
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			mailbox_owner_reg <= MBX_ZERO_WORD;
		end else if (ce) begin
			if (ownerClear) begin
				mailbox_owner_reg <= MBX_ZERO_WORD;
			end else if (ownerLoad) begin
				mailbox_owner_reg <= commitData;
			end
		end
	end

	// Strobe for the data words kept outside this block
	always_ff @(posedge clk) begin
		if (rst) begin
			ownerClearPulse <= 1'b0;
		end else if (ce) begin
			ownerClearPulse <= ownerClear;
		end
	end

	// ----------------------------------------
	// Mode
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			mailbox_mode_reg <= MBX_MODE_RESET;
		end else if (ce) begin
			if (ownerClear) begin
				mailbox_mode_reg <= MBX_MODE_RESET;
			end else if (wrMode) begin
				mailbox_mode_reg <= commitData[1:0];
			end
		end
	end

	// ----------------------------------------
	// Send and auto acknowledge
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			destWasSet_reg <= 1'b0;
		end else if (ce) begin
			destWasSet_reg <= |destVec;
		end
	end

	// Falling edge of the destination vector while messaging destinations
	assign autoAckFire = claimed && mailbox_mode_reg[MBX_MODE_ACK_BIT] && destWasSet_reg
		&& destVec == MBX_ZERO_WORD && send_control_reg == MBX_SEND_DEST;

	// Acknowledge turned into a hand-off to the next mailbox
	assign linkFire = mailbox_mode_reg[MBX_MODE_LINK_BIT] && !ownerClear && (autoAckFire
		|| (wrSend && commitData[1:0] == MBX_SEND_SRC));

	// Hardware acknowledge outranks a software write landing in the same cycle
	always_comb begin
		send_control_next = send_control_reg;
		if (ownerClear) begin
			send_control_next = MBX_SEND_IDLE;
		end else if (autoAckFire) begin
			send_control_next = mailbox_mode_reg[MBX_MODE_LINK_BIT] ? MBX_SEND_IDLE
				: MBX_SEND_SRC;
		end else if (wrSend) begin
			send_control_next = linkFire ? MBX_SEND_IDLE : commitData[1:0];
		end else if (linkPrevSend && claimed) begin
			send_control_next = MBX_SEND_DEST;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			send_control_reg <= MBX_SEND_IDLE;
		end else if (ce) begin
			send_control_reg <= send_control_next;
		end
	end

	// The last mailbox of the chain has no successor
	always_ff @(posedge clk) begin
		if (rst) begin
			linkNextSend <= 1'b0;
		end else if (ce) begin
			linkNextSend <= linkFire && (MAILBOX_INDEX < MBX_LAST_MAILBOX);
		end
	end

	// ----------------------------------------
	// Interrupt lines
	// ----------------------------------------
	// Invalid send code 11 raises nothing
	assign rawIrq = (send_control_reg == MBX_SEND_DEST ? destVec : MBX_ZERO_WORD)
		| (send_control_reg == MBX_SEND_SRC ? mailbox_owner_reg : MBX_ZERO_WORD);

	always_ff @(posedge clk) begin
		if (rst) begin
			channel_irq_out <= MBX_ZERO_WORD;
		end else if (ce) begin
			channel_irq_out <= rawIrq & maskVec;
		end
	end

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always_comb begin
		case (avs_address)
			MBX_OFS_OWNER: readWord = mailbox_owner_reg;
			MBX_OFS_DSTAT: readWord = destVec;
			MBX_OFS_MODE: readWord = {30'h0, mailbox_mode_reg};
			MBX_OFS_MSTAT: readWord = maskVec;
			MBX_OFS_SEND: readWord = {30'h0, send_control_reg};
			default: readWord = MBX_ZERO_WORD;
		endcase
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_owner_claim_lock: assert property (
		ce && claimed && wrOwner && commitData != MBX_ZERO_WORD
		|=> mailbox_owner_reg == $past(mailbox_owner_reg))
		else $error("owner overwritten while claimed");

	chk_dest_set_or: assert property (
		ce && claimed && commitWrite && commitAddr == MBX_OFS_DSET
		|=> destVec == ($past(destVec) | $past(commitData)))
		else $error("destination set did not OR in");

	chk_dest_clr_and: assert property (
		ce && claimed && commitWrite && commitAddr == MBX_OFS_DCLR
		|=> destVec == ($past(destVec) & ~$past(commitData)))
		else $error("destination clear wrong");

	chk_owner_clear_dest: assert property (
		ce && ownerClear |=> destVec == MBX_ZERO_WORD && mailbox_owner_reg == MBX_ZERO_WORD)
		else $error("destination survived owner clear");

	chk_clear_mode_send: assert property (
		ce && ownerClear |=> mailbox_mode_reg == MBX_MODE_RESET
			&& send_control_reg == MBX_SEND_IDLE)
		else $error("mode or send survived owner clear");

	chk_clear_mask_all: assert property (
		ce && ownerClear |=> maskVec == MBX_ZERO_WORD
			##1 (!$past(ce) || channel_irq_out == MBX_ZERO_WORD))
		else $error("mask or interrupt survived owner clear");

	chk_mode_unclaimed_zero: assert property (
		!claimed |-> mailbox_mode_reg == MBX_MODE_RESET)
		else $error("mode held while unclaimed");

	chk_unclaimed_ignored: assert property (
		ce && !claimed && commitWrite && commitAddr != MBX_OFS_OWNER
		|=> $stable(destVec) && $stable(maskVec) && $stable(send_control_reg))
		else $error("write took effect while unclaimed");

	chk_auto_ack_turn: assert property (
		ce && autoAckFire && !mailbox_mode_reg[MBX_MODE_LINK_BIT]
		|=> send_control_reg == MBX_SEND_SRC)
		else $error("auto acknowledge did not turn send");

	chk_link_handoff: assert property (
		ce && linkFire |=> send_control_reg == MBX_SEND_IDLE
			&& linkNextSend == (MAILBOX_INDEX < MBX_LAST_MAILBOX))
		else $error("auto link hand-off wrong");

	chk_irq_dest_lines: assert property (
		ce && send_control_reg == MBX_SEND_DEST
		|=> channel_irq_out == ($past(destVec) & $past(maskVec)))
		else $error("destination interrupt lines wrong");

	chk_irq_ack_line: assert property (
		ce && send_control_reg == MBX_SEND_SRC
		|=> channel_irq_out == ($past(mailbox_owner_reg) & $past(maskVec)))
		else $error("acknowledge line wrong");

	chk_send_idle_quiet: assert property (
		ce && send_control_reg == MBX_SEND_IDLE |=> channel_irq_out == MBX_ZERO_WORD)
		else $error("interrupt with send idle");

	chk_mode_write_bits: assert property (
		ce && wrMode
		|=> {30'h0, mailbox_mode_reg} == ($past(commitData) & 32'h0000_0003))
		else $error("mode write stored wrong bits");

	chk_send_write_store: assert property (
		ce && wrSend && !autoAckFire && !linkFire
		|=> {30'h0, send_control_reg} == ($past(commitData) & 32'h0000_0003))
		else $error("send write stored wrong code");

	chk_link_pickup: assert property (
		ce && linkPrevSend && claimed && !ownerClear && !autoAckFire && !wrSend
		|=> send_control_reg == MBX_SEND_DEST)
		else $error("linked message not picked up");

	chk_owner_pulse: assert property (
		ce && ownerClear |=> ownerClearPulse)
		else $error("owner clear strobe missing");

	chk_mask_set_or: assert property (
		ce && claimed && commitWrite && commitAddr == MBX_OFS_MSET
		|=> maskVec == ($past(maskVec) | $past(commitData)))
		else $error("mask set did not OR in");

	chk_mask_clr_and: assert property (
		ce && claimed && commitWrite && commitAddr == MBX_OFS_MCLR
		|=> maskVec == ($past(maskVec) & ~$past(commitData)))
		else $error("mask clear wrong");

	cov_claim: cover property (ce && ownerLoad);
	cov_refused_claim: cover property (ce && claimed && wrOwner && !ownerClear);
	cov_auto_ack: cover property (ce && autoAckFire ##2 channel_irq_out != MBX_ZERO_WORD);
	cov_link: cover property (ce && linkFire);
endmodule

// File: mbx_pkg.sv
package mbx_pkg;

	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int MBX_DW = 32;
	localparam int MBX_AW = 6;
	localparam int MBX_BW = 4;

	// ----------------------------------------
	// Register byte offsets inside one mailbox
	// ----------------------------------------
	localparam logic [5:0] MBX_OFS_OWNER = 6'h00;
	localparam logic [5:0] MBX_OFS_DSET = 6'h04;
	localparam logic [5:0] MBX_OFS_DCLR = 6'h08;
	localparam logic [5:0] MBX_OFS_DSTAT = 6'h0C;
	localparam logic [5:0] MBX_OFS_MODE = 6'h10;
	localparam logic [5:0] MBX_OFS_MSET = 6'h14;
	localparam logic [5:0] MBX_OFS_MCLR = 6'h18;
	localparam logic [5:0] MBX_OFS_MSTAT = 6'h1C;
	localparam logic [5:0] MBX_OFS_SEND = 6'h20;

	// ----------------------------------------
	// Reset values and field layout
	// ----------------------------------------
	localparam logic [31:0] MBX_ZERO_WORD = 32'h0000_0000;
	localparam logic [1:0] MBX_MODE_RESET = 2'h0;
	localparam int MBX_MODE_ACK_BIT = 0;
	localparam int MBX_MODE_LINK_BIT = 1;
	localparam logic [1:0] MBX_SEND_IDLE = 2'h0;
	localparam logic [1:0] MBX_SEND_DEST = 2'h1;
	localparam logic [1:0] MBX_SEND_SRC = 2'h2;
	localparam int MBX_LAST_MAILBOX = 31;

	// ----------------------------------------
	// Bus handshake states
	// ----------------------------------------
	typedef enum logic [0:0] {
		MBX_BUS_IDLE = 1'b0,
		MBX_BUS_ANSWER = 1'b1
	} mbx_bus_e;

	// Byte enables widened to a bit mask
	function automatic logic [31:0] mbx_be_mask(input logic [3:0] be);
		logic [31:0] m;
		m = MBX_ZERO_WORD;
		for (int i = 0; i < MBX_BW; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

endpackage

// File: mbx_setclr_vec.sv
`timescale 1ns/1ps
module mbx_setclr_vec
	import mbx_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic clearAll,
	input wire logic setEn,
	input wire logic clrEn,
	input wire logic [31:0] bits,
	output logic [31:0] value
);
	// ----------------------------------------
	// Set / clear vector
	// ----------------------------------------
	// Whole-vector clear outranks any write in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			value <= MBX_ZERO_WORD;
		end else if (ce) begin
			if (clearAll) begin
				value <= MBX_ZERO_WORD;
			end else if (setEn) begin
				value <= value | bits;
			end else if (clrEn) begin
				value <= value & ~bits;
			end
		end
	end
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import mbx_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk, rst, ce, linkPrevSend, go, goRead, done;
	logic [5:0] goAddr, avs_address;
	logic [31:0] goData, rdata, avs_writedata, avs_readdata, channel_irq_out;
	logic avs_read, avs_write, avs_waitrequest, linkNextSend, ownerClearPulse;
	logic [3:0] avs_byteenable;
	logic sawClr, sawLink;
	int failures, total_checks;

	mbx_core_model i_core (.clk(clk), .rst(rst), .go(go), .goRead(goRead),
		.goAddr(goAddr), .goData(goData), .done(done), .rdata(rdata),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata));

	mbx_mailbox_regs i_dut (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .linkPrevSend(linkPrevSend),
		.linkNextSend(linkNextSend), .ownerClearPulse(ownerClearPulse),
		.channel_irq_out(channel_irq_out));

	initial forever #4 clk = ~clk;

	// Pulses are one cycle; sticky flags catch them
	always @(posedge clk) begin
		if (ownerClearPulse === 1'b1) sawClr <= 1'b1;
		if (linkNextSend === 1'b1) sawLink <= 1'b1;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task end_of_test;
		if (failures == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task xfer(input logic isRd, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		go <= 1'b1;
		goRead <= isRd;
		goAddr <= a;
		goData <= d;
		@(posedge clk);
		go <= 1'b0;
		// No limit here; the watchdog ends a hung transfer
		do begin
			@(posedge clk);
			#1;
		end while (done !== 1'b1);
	endtask

	task wr(input logic [5:0] a, input logic [31:0] d);
		xfer(1'b0, a, d);
	endtask

	task rd(input logic [5:0] a, input logic [31:0] exp);
		xfer(1'b1, a, 32'h0);
		check(rdata, exp);
	endtask

	// Irq lags register state by one edge
	task irq(input logic [31:0] exp);
		repeat (2) @(posedge clk);
		#1;
		check(channel_irq_out, exp);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		for (int i = 0; i < 9; i++) rd(6'(i * 4), 32'h0);
		irq(32'h0);
	endtask

	task t_unclaimed;
		wr(MBX_OFS_DSET, 32'hF);
		wr(MBX_OFS_MSET, 32'hF);
		wr(MBX_OFS_MODE, 32'h3);
		wr(MBX_OFS_SEND, 32'h1);
		rd(MBX_OFS_DSTAT, 32'h0);
		rd(MBX_OFS_MSTAT, 32'h0);
		rd(MBX_OFS_MODE, 32'h0);
		rd(MBX_OFS_SEND, 32'h0);
		irq(32'h0);
	endtask

	task t_claim;
		wr(MBX_OFS_OWNER, 32'h1);
		wr(MBX_OFS_OWNER, 32'h4);
		rd(MBX_OFS_OWNER, 32'h1);
		wr(6'h24, 32'hFFFF_FFFF);
		rd(6'h24, 32'h0);
	endtask

	task t_dest_mask;
		wr(MBX_OFS_DSET, 32'h6);
		wr(MBX_OFS_DSET, 32'h8);
		rd(MBX_OFS_DSTAT, 32'hE);
		wr(MBX_OFS_DCLR, 32'h4);
		rd(MBX_OFS_DSTAT, 32'hA);
		wr(MBX_OFS_MSET, 32'hF);
		wr(MBX_OFS_MCLR, 32'h2);
		rd(MBX_OFS_MSTAT, 32'hD);
	endtask

	task t_send;
		wr(MBX_OFS_MODE, 32'hFFFF_FFFF);
		rd(MBX_OFS_MODE, 32'h3);
		wr(MBX_OFS_MODE, 32'h0);
		wr(MBX_OFS_SEND, 32'h1);
		irq(32'h8);
		wr(MBX_OFS_SEND, 32'h0);
		irq(32'h0);
		wr(MBX_OFS_SEND, 32'h2);
		irq(32'h1);
	endtask

	task t_autoack;
		wr(MBX_OFS_MODE, 32'h1);
		wr(MBX_OFS_SEND, 32'h1);
		irq(32'h8);
		wr(MBX_OFS_DCLR, 32'h2);
		rd(MBX_OFS_SEND, 32'h1);
		wr(MBX_OFS_DCLR, 32'h8);
		rd(MBX_OFS_SEND, 32'h2);
		irq(32'h1);
	endtask

	task t_owner_clear;
		wr(MBX_OFS_DSET, 32'h3);
		wr(MBX_OFS_OWNER, 32'h0);
		rd(MBX_OFS_OWNER, 32'h0);
		rd(MBX_OFS_DSTAT, 32'h0);
		rd(MBX_OFS_MODE, 32'h0);
		rd(MBX_OFS_SEND, 32'h0);
		rd(MBX_OFS_MSTAT, 32'h0);
		check({31'h0, sawClr}, 32'h1);
		irq(32'h0);
	endtask

	task t_link;
		check({31'h0, sawLink}, 32'h0);
		wr(MBX_OFS_OWNER, 32'h2);
		wr(MBX_OFS_MODE, 32'h3);
		wr(MBX_OFS_DSET, 32'h1);
		wr(MBX_OFS_MSET, 32'h3);
		wr(MBX_OFS_SEND, 32'h1);
		irq(32'h1);
		wr(MBX_OFS_DCLR, 32'h1);
		rd(MBX_OFS_SEND, 32'h0);
		check({31'h0, sawLink}, 32'h1);
		irq(32'h0);
		@(posedge clk);
		linkPrevSend <= 1'b1;
		@(posedge clk);
		linkPrevSend <= 1'b0;
		rd(MBX_OFS_SEND, 32'h1);
	endtask

	// A hand-off arriving while frozen must be lost
	task t_freeze;
		wr(MBX_OFS_SEND, 32'h0);
		@(posedge clk);
		ce <= 1'b0;
		linkPrevSend <= 1'b1;
		@(posedge clk);
		linkPrevSend <= 1'b0;
		@(posedge clk);
		ce <= 1'b1;
		rd(MBX_OFS_SEND, 32'h0);
		irq(32'h0);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		linkPrevSend = 1'b0;
		go = 1'b0;
		goRead = 1'b0;
		goAddr = 6'h0;
		goData = 32'h0;
		sawClr = 1'b0;
		sawLink = 1'b0;
		failures = 0;
		total_checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_unclaimed();
		t_claim();
		t_dest_mask();
		t_send();
		t_autoack();
		t_owner_clear();
		t_link();
		t_freeze();
		end_of_test();
	end

	initial begin
		#100000;
		failures++;
		end_of_test();
	end
endmodule
